// ---- rtl/sf_em_pkg.sv ----
package sf_em_pkg;

    // Clock and the one-millisecond timing tick.
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned TICK_PERIOD_NS = 1000000;
    localparam int unsigned TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_W = 18;

    // Millisecond counters saturate well above the longest delay.
    localparam int unsigned CNT_W = 9;
    localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
    localparam logic [CNT_W-1:0] CNT_MAX = 9'h1FF;

    // Transmit section delays in milliseconds (18, 400, 50).
    localparam logic [CNT_W-1:0] M_DELAY_MS = 9'h012;
    localparam logic [CNT_W-1:0] AUG_LEVEL_MS = 9'h190;
    localparam logic [CNT_W-1:0] MIN_BURST_MS = 9'h032;

    // Receive section delays in milliseconds (225, 50, 13, 225, 50, 60, 33, 50).
    localparam logic [CNT_W-1:0] GUARD_HL_MS = 9'h0E1;
    localparam logic [CNT_W-1:0] GUARD_LH_MS = 9'h032;
    localparam logic [CNT_W-1:0] BEF_INSERT_MS = 9'h00D;
    localparam logic [CNT_W-1:0] BEF_REMOVE_MS = 9'h0E1;
    localparam logic [CNT_W-1:0] BEF_TAIL_MS = 9'h032;
    localparam logic [CNT_W-1:0] SEIZE_MS = 9'h03C;
    localparam logic [CNT_W-1:0] RELEASE_MS = 9'h021;
    localparam logic [CNT_W-1:0] E_MIN_BREAK_MS = 9'h032;

    // Reset values of the control outputs: idle trunk, tone sent, path cut.
    localparam logic TONE_KEY_RST = 1'b1;
    localparam logic PATH_CUT_RST = 1'b1;
    localparam logic BUSY_RST = 1'b0;
    localparam logic HIGH_LEVEL_RST = 1'b0;
    localparam logic GUARD_LOW_RST = 1'b0;
    localparam logic BEF_RST = 1'b0;

    typedef enum logic {
        E_OPEN,
        E_GROUND
    } e_lead_state_t;

endpackage

// ---- rtl/sf_em_signaling_timing.sv ----
// Contract
// RULE1: Tone changes after M-lead held 18 ms.
// RULE2: Tone idle, none busy, breaks while dialing.
// RULE3: Normal polarity: battery busy, open idle.
// RULE4: Inverted polarity: battery idle, open busy.
// RULE5: High tone level 400 ms after hangup.
// RULE6: Ignore on-hook pulses shorter than delay.
// RULE7: Stretch short tone bursts to 50 ms.
// RULE8: Longer bursts follow on-hook interval length.
// RULE9: Cut speech path 18 ms before tone.
// RULE10: Restore speech path on local seizure.
// RULE11: Guard switches after 225 / 50 ms.
// RULE12: Insert band filter 13 ms after tone.
// RULE13: Remove filter after longer of two timings.
// RULE14: Short received breaks stretched to 50 ms.
// RULE15: Long received breaks keep their length; the code makes them 27 ms shorter (60 ms seizure delay, 33 ms release delay).
// RULE16: Ground E lead 60 ms after tone loss.
// RULE17: Open E lead 33 ms after tone returns.
// RULE18: All delays counted on millisecond tick.
// RULE19: Ignore received breaks shorter than seizure delay.
module sf_em_signaling_timing #(
    parameter int unsigned TICK_CYCLES = sf_em_pkg::TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Trunk side
    input wire logic m_lead_battery_i,
    input wire logic m_lead_polarity_switch_i,
    output logic e_lead_ground_o,
    // Facility side
    input wire logic tone_detect_i,
    output logic tone_key_o,
    output logic tone_high_level_o,
    output logic xmt_path_cut_o,
    output logic guard_low_o,
    output logic bef_insert_o
);
    import sf_em_pkg::*;

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c, input logic en);
        sat_inc = (en && (c != CNT_MAX)) ? c + 9'h001 : c;
    endfunction

    // Millisecond tick.
    logic [TICK_W-1:0] tick_cnt_q;
    logic [TICK_W-1:0] tick_cnt_d;
    logic tick;
    assign tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)); // RULE18
    assign tick_cnt_d = tick ? '0 : tick_cnt_q + 18'h00001;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // Transmit section.
    logic busy_q;
    logic busy_d;
    logic busy_raw;
    logic m_differs;
    logic m_done;
    logic [CNT_W-1:0] mdly_cnt_q;
    logic [CNT_W-1:0] mdly_cnt_d;
    logic tone_key_q;
    logic tone_key_d;
    logic [CNT_W-1:0] burst_cnt_q;
    logic [CNT_W-1:0] burst_cnt_d;
    logic hangup;
    logic [CNT_W-1:0] aug_cnt_q;
    logic [CNT_W-1:0] aug_cnt_d;
    logic aug_q;
    logic cut_q;
    logic cut_d;

    // Normal setting: battery means busy; the inverted setting swaps it.
    assign busy_raw = m_lead_battery_i ^ m_lead_polarity_switch_i; // RULE3 RULE4
    assign m_differs = busy_raw != busy_q;
    // A pulse that ends before the delay clears the counter and never reaches the tone.
    assign mdly_cnt_d = m_differs ? sat_inc(mdly_cnt_q, tick) : CNT_ZERO; // RULE6
    assign m_done = m_differs && (mdly_cnt_q >= M_DELAY_MS); // RULE1
    assign busy_d = m_done ? busy_raw : busy_q;

    // Both edges lag by the same delay, so a long burst keeps the interval length.
    assign tone_key_d = !busy_q || (tone_key_q && (burst_cnt_q < MIN_BURST_MS)); // RULE2 RULE7 RULE8
    assign burst_cnt_d = tone_key_q ? sat_inc(burst_cnt_q, tick) : CNT_ZERO;

    assign hangup = busy_q && !busy_d;
    assign aug_cnt_d = hangup ? AUG_LEVEL_MS :
                       ((tick && (aug_cnt_q != CNT_ZERO)) ? aug_cnt_q - 9'h001 : aug_cnt_q); // RULE5

    // The cut rises as soon as the M lead leaves busy, one full delay before the tone.
    assign cut_d = !(busy_q && busy_raw && !tone_key_d); // RULE9 RULE10

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            busy_q <= BUSY_RST;
            mdly_cnt_q <= CNT_ZERO;
            tone_key_q <= TONE_KEY_RST;
            burst_cnt_q <= CNT_ZERO;
            aug_cnt_q <= CNT_ZERO;
            aug_q <= HIGH_LEVEL_RST;
            cut_q <= PATH_CUT_RST;
        end else begin
            busy_q <= busy_d;
            mdly_cnt_q <= mdly_cnt_d;
            tone_key_q <= tone_key_d;
            burst_cnt_q <= burst_cnt_d;
            aug_cnt_q <= aug_cnt_d;
            aug_q <= aug_cnt_d != CNT_ZERO;
            cut_q <= cut_d;
        end
    end

    assign tone_key_o = tone_key_q;
    assign tone_high_level_o = aug_q;
    assign xmt_path_cut_o = cut_q;

    // Receive section.
    logic [CNT_W-1:0] tone_cnt_q;
    logic [CNT_W-1:0] tone_cnt_d;
    logic [CNT_W-1:0] gap_cnt_q;
    logic [CNT_W-1:0] gap_cnt_d;
    logic guard_low_q;
    logic guard_low_d;
    logic bef_q;
    logic bef_d;
    logic [CNT_W-1:0] bef_age_q;
    logic [CNT_W-1:0] bef_age_d;
    logic bef_remove;
    e_lead_state_t e_state_q;
    e_lead_state_t e_state_d;
    logic [CNT_W-1:0] e_hold_cnt_q;
    logic [CNT_W-1:0] e_hold_cnt_d;
    logic e_release_ok;

    assign tone_cnt_d = tone_detect_i ? sat_inc(tone_cnt_q, tick) : CNT_ZERO;
    // A returning tone restarts the gap count, so a short break leaves the E lead open.
    assign gap_cnt_d = tone_detect_i ? CNT_ZERO : sat_inc(gap_cnt_q, tick); // RULE19

    assign guard_low_d = guard_low_q ? !(gap_cnt_q >= GUARD_LH_MS) : (tone_cnt_q >= GUARD_HL_MS); // RULE11

    assign bef_remove = (gap_cnt_q >= BEF_TAIL_MS) && (bef_age_q >= BEF_REMOVE_MS); // RULE13
    assign bef_d = bef_q ? !bef_remove : (tone_cnt_q >= BEF_INSERT_MS); // RULE12
    assign bef_age_d = bef_q ? sat_inc(bef_age_q, tick) : CNT_ZERO;

    assign e_hold_cnt_d = (e_state_q == E_GROUND) ? sat_inc(e_hold_cnt_q, tick) : CNT_ZERO;
    // The lead stays grounded at least the minimum break, then follows the tone.
    assign e_release_ok = (tone_cnt_q >= RELEASE_MS) && (e_hold_cnt_q >= E_MIN_BREAK_MS); // RULE14 RULE15 RULE17

    always_comb begin
        e_state_d = e_state_q;
        unique case (e_state_q)
            E_OPEN: begin
                if (gap_cnt_q >= SEIZE_MS) begin
                    e_state_d = E_GROUND; // RULE16
                end
            end
            E_GROUND: begin
                if (e_release_ok) begin
                    e_state_d = E_OPEN;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            tone_cnt_q <= CNT_ZERO;
            gap_cnt_q <= CNT_ZERO;
            guard_low_q <= GUARD_LOW_RST;
            bef_q <= BEF_RST;
            bef_age_q <= CNT_ZERO;
            e_state_q <= E_OPEN;
            e_hold_cnt_q <= CNT_ZERO;
        end else begin
            tone_cnt_q <= tone_cnt_d;
            gap_cnt_q <= gap_cnt_d;
            guard_low_q <= guard_low_d;
            bef_q <= bef_d;
            bef_age_q <= bef_age_d;
            e_state_q <= e_state_d;
            e_hold_cnt_q <= e_hold_cnt_d;
        end
    end

    assign guard_low_o = guard_low_q;
    assign bef_insert_o = bef_q;
    assign e_lead_ground_o = e_state_q == E_GROUND;

    // Checks.
    tick_period_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE18
        tick |=> !tick)
        else $error("tick lasted more than one cycle");

    m_delay_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE1
        (busy_q != $past(busy_q)) |-> ($past(mdly_cnt_q) == M_DELAY_MS))
        else $error("M-lead state taken without full delay");

    polarity_map_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE3
        $rose(busy_q) |-> $past(m_lead_battery_i != m_lead_polarity_switch_i))
        else $error("busy taken against polarity setting");

    inv_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE4
        $fell(busy_q) |-> $past(m_lead_battery_i == m_lead_polarity_switch_i))
        else $error("idle taken against polarity setting");

    idle_tone_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE2
        !busy_q |=> tone_key_o)
        else $error("no tone while idle");

    min_burst_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE7
        $fell(tone_key_o) |-> ($past(burst_cnt_q) >= MIN_BURST_MS) && $past(busy_q))
        else $error("tone burst shorter than minimum");

    aug_level_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE5
        $fell(busy_q) |-> tone_high_level_o && (aug_cnt_q == AUG_LEVEL_MS))
        else $error("high level not started at hangup");

    cut_before_tone_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE9
        $rose(tone_key_o) |-> $past(xmt_path_cut_o, 2))
        else $error("tone sent before path cut");

    cut_release_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE10
        (busy_q && busy_raw && !tone_key_q) |=> !xmt_path_cut_o)
        else $error("path cut kept after seizure");

    guard_switch_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE11
        $rose(guard_low_o) |-> ($past(tone_cnt_q) >= GUARD_HL_MS))
        else $error("guard went low early");

    bef_insert_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE12
        $rose(bef_insert_o) |-> ($past(tone_cnt_q) >= BEF_INSERT_MS))
        else $error("band filter inserted early");

    bef_remove_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE13
        $fell(bef_insert_o) |-> ($past(bef_age_q) >= BEF_REMOVE_MS) && ($past(gap_cnt_q) >= BEF_TAIL_MS))
        else $error("band filter removed early");

    e_seize_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE16
        $rose(e_lead_ground_o) |-> ($past(gap_cnt_q) >= SEIZE_MS))
        else $error("E lead grounded early");

    e_release_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE17
        $fell(e_lead_ground_o) |-> ($past(tone_cnt_q) >= RELEASE_MS) && ($past(e_hold_cnt_q) >= E_MIN_BREAK_MS))
        else $error("E lead opened early");

    mdly_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE1
        (m_differs && (mdly_cnt_q < M_DELAY_MS)) |=> $stable(busy_q))
        else $error("M-lead state taken before delay ran out");

    m_restart_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE6
        !m_differs |=> (mdly_cnt_q == CNT_ZERO))
        else $error("M-lead delay not restarted after short pulse");

    busy_silent_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE2
        (busy_q && (burst_cnt_q >= MIN_BURST_MS)) |=> !tone_key_o)
        else $error("tone sent while busy");

    tone_stretch_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE7
        (tone_key_o && (burst_cnt_q < MIN_BURST_MS)) |=> tone_key_o)
        else $error("tone burst cut short");

    cut_early_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE9
        !busy_raw |=> xmt_path_cut_o)
        else $error("path not cut while M lead idle");

    guard_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE11
        (!guard_low_o && (tone_cnt_q < GUARD_HL_MS)) |=> !guard_low_o)
        else $error("guard left high state early");

    guard_return_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE11
        $fell(guard_low_o) |-> ($past(gap_cnt_q) >= GUARD_LH_MS))
        else $error("guard returned high early");

    bef_wait_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE12
        (!bef_insert_o && (tone_cnt_q < BEF_INSERT_MS)) |=> !bef_insert_o)
        else $error("band filter inserted before delay");

    bef_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE13
        (bef_insert_o && (gap_cnt_q < BEF_TAIL_MS)) |=> bef_insert_o)
        else $error("band filter dropped within tail");

    e_ignore_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE19
        (!e_lead_ground_o && (gap_cnt_q < SEIZE_MS)) |=> !e_lead_ground_o)
        else $error("E lead grounded on short break");

    burst_seen_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        $fell(tone_key_o) && ($past(burst_cnt_q) == MIN_BURST_MS));

    aug_seen_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        $fell(tone_high_level_o));

    seize_seen_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(e_lead_ground_o));

    bef_seen_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        $fell(bef_insert_o));

    e_stretch_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        $fell(e_lead_ground_o) && ($past(tone_cnt_q) > RELEASE_MS));

endmodule // sf_em_signaling_timing

// ---- tb/far_end_model.sv ----
module far_end_model (
    // Clock
    input wire logic clk_i,
    // Commands from the bench
    input wire logic trunk_busy_i,
    input wire logic polarity_inv_i,
    input wire logic tone_on_i,
    // Lines into the block
    output logic m_lead_battery_o,
    output logic tone_detect_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        m_lead_battery_o = 1'b0;
        tone_detect_o = 1'b1;
    end

    // The trunk puts battery on for busy in normal mode and for idle in inverted mode.
    always @(posedge clk_i) begin
        m_lead_battery_o <= trunk_busy_i ^ polarity_inv_i;
        tone_detect_o <= tone_on_i;
    end
endmodule // far_end_model

// ---- tb/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sf_em_pkg::*;

    // One millisecond is shortened to four clocks so that the run stays short.
    localparam int TC = 4;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic m_busy = 1'b0;
    logic pol_inv = 1'b0;
    logic tone_on = 1'b1;
    logic m_batt, tone_det, e_gnd, tone_key, high_lvl, cut, guard_low, bef;
    logic [5:0] outs;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;
    int len;

    assign outs = {e_gnd, bef, guard_low, high_lvl, cut, tone_key};

    far_end_model i_far (.clk_i(clk_i), .trunk_busy_i(m_busy), .polarity_inv_i(pol_inv), .tone_on_i(tone_on),
        .m_lead_battery_o(m_batt), .tone_detect_o(tone_det));

    sf_em_signaling_timing #(.TICK_CYCLES(TC)) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .m_lead_battery_i(m_batt), .m_lead_polarity_switch_i(pol_inv), .e_lead_ground_o(e_gnd),
        .tone_detect_i(tone_det), .tone_key_o(tone_key), .tone_high_level_o(high_lvl),
        .xmt_path_cut_o(cut), .guard_low_o(guard_low), .bef_insert_o(bef));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic end_sim();
        $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // A hang would otherwise stall the run forever.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            end_sim();
        end
    end

    // Waits n milliseconds and steps past the edge so outputs are settled.
    task automatic ms(input int n);
        repeat (n * TC) @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input logic [5:0] got, input logic [5:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("mismatch %0t got %h exp %h", $time, got, lo);
        end
    endtask

    // Checks that one output keeps its value for a whole span.
    task automatic hold(input int idx, input logic exp, input int n_ms);
        logic bad = 1'b0;
        repeat (n_ms * TC) begin
            @(posedge clk_i);
            #1;
            if (outs[idx] !== exp) bad = 1'b1;
        end
        chk(bad, 1'b0);
    endtask

    // Length in milliseconds of the next stretch where an output holds val.
    task automatic meas(input int idx, input logic val, output int n_ms);
        int n = 0;
        int w = 0;
        while (outs[idx] !== val && w < 2000) begin
            @(posedge clk_i);
            #1;
            w++;
        end
        while (outs[idx] === val && n < 4000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        n_ms = n / TC;
    endtask

    task automatic t_rx_seize();
        hold(4, 1'b0, 5);
        ms(16);
        chk(bef, 1'b1);
        hold(3, 1'b0, 139);
        ms(126);
        chk(guard_low, 1'b1);
        @(posedge clk_i) tone_on <= 1'b0;
        hold(5, 1'b0, 39);
        chk({guard_low, bef}, 2'h3);
        ms(22);
        chk({guard_low, bef}, 2'h0);
        ms(20);
        chk(e_gnd, 1'b1);
        @(posedge clk_i) tone_on <= 1'b1;
        hold(5, 1'b1, 29);
        ms(8);
        chk(e_gnd, 1'b0);
        $display("test rx_seize done");
    endtask

    task automatic t_tx_seize();
        @(posedge clk_i) m_busy <= 1'b1;
        hold(0, 1'b1, 12);
        ms(13);
        chk({cut, tone_key}, 2'h0);
        @(posedge clk_i) m_busy <= 1'b0;
        ms(1);
        chk(cut, 1'b1);
        hold(0, 1'b0, 12);
        ms(12);
        chk({high_lvl, tone_key}, 2'h3);
        hold(2, 1'b1, 280);
        ms(215);
        chk(high_lvl, 1'b0);
        $display("test tx_seize done");
    endtask

    task automatic t_tx_pulse();
        @(posedge clk_i) m_busy <= 1'b1;
        ms(25);
        @(posedge clk_i) m_busy <= 1'b0;
        ms(10);
        @(posedge clk_i) m_busy <= 1'b1;
        hold(0, 1'b0, 40);
        fork
            begin
                @(posedge clk_i) m_busy <= 1'b0;
                ms(30);
                @(posedge clk_i) m_busy <= 1'b1;
            end
            meas(0, 1'b1, len);
        join
        chk_rng(len, 48, 52);
        ms(30);
        fork
            begin
                @(posedge clk_i) m_busy <= 1'b0;
                ms(80);
                @(posedge clk_i) m_busy <= 1'b1;
            end
            meas(0, 1'b1, len);
        join
        chk_rng(len, 78, 82);
        @(posedge clk_i) m_busy <= 1'b0;
        ms(30);
        $display("test tx_pulse done");
    endtask

    task automatic t_tx_inv();
        @(posedge clk_i) pol_inv <= 1'b1;
        hold(0, 1'b1, 30);
        @(posedge clk_i) m_busy <= 1'b1;
        ms(25);
        chk(tone_key, 1'b0);
        $display("test tx_inv done");
    endtask

    task automatic t_rx_break();
        @(posedge clk_i) tone_on <= 1'b0;
        hold(5, 1'b0, 30);
        @(posedge clk_i) tone_on <= 1'b1;
        hold(5, 1'b0, 60);
        fork
            begin
                @(posedge clk_i) tone_on <= 1'b0;
                ms(65);
                @(posedge clk_i) tone_on <= 1'b1;
            end
            meas(5, 1'b1, len);
        join
        // A break just past the seizure delay still grounds the lead for the minimum time.
        chk_rng(len, 48, 52);
        fork
            begin
                @(posedge clk_i) tone_on <= 1'b0;
                ms(120);
                @(posedge clk_i) tone_on <= 1'b1;
            end
            meas(5, 1'b1, len);
        join
        // The E-lead break is the tone break moved by the seizure and release delays.
        chk_rng(len, 117 - int'(SEIZE_MS) + int'(RELEASE_MS), 123 - int'(SEIZE_MS) + int'(RELEASE_MS));
        $display("test rx_break done");
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
        chk(outs, 6'h03);
        t_rx_seize();
        t_tx_seize();
        t_tx_pulse();
        t_tx_inv();
        t_rx_break();
        end_sim();
    end
endmodule // testbench
